// file: test_tls_line_sup.sv
`timescale 1ns/100ps
`default_nettype none
module test_tls_line_sup;
  import tls_pkg::*;
  logic clk = 1'b0, rst = 1'b1, coder_req = 1'b0, tx_in_vld = 1'b0, is_exch = 1'b1;
  tls_el_e tx_el = EL_IDLE;
  logic [3:0] tx_in_data = 4'h0;
  logic tx_in_rdy, tx_sync_q, tone_done_q, ones_done_q, rx_align, rx_frame, line_pos;
  logic cv_q, rx_sync_q, det_zero_q, det_ones_q, det_burst_q, det_idle_q, wake_q;
  logic [2:0] rds_col_q;
  tls_nib_s tx_nib_q, rx_nib, rx_out_q;
  tls_sym_s tx_sym_q, rx_sym;
  int n_mismatch = 0, n_tests = 0, seed = 48, sum_m = 1, n_rx = 0, n_tx = 0, n_wake = 0;
  logic [2:0] col_m = 3'h1;
  logic [22:0] dsc_q = 23'h00_0000;
  logic [3:0] fq[$];
  logic [4:0] g;
  logic rdy_s;
  int w;
  tls_el_e els[3] = '{EL_UNFR0, EL_FRM0, EL_ONES};

  tls_line_sup #(.QUIET_CYCLES(50), .BURST_CYCLES(40)) tls_line_sup_i (
    .clk(clk), .rst(rst), .is_exch(is_exch), .tx_el(tx_el),
    .tx_in_vld(tx_in_vld), .tx_in_data(tx_in_data), .tx_in_rdy(tx_in_rdy),
    .coder_req(coder_req), .tx_nib_q(tx_nib_q), .tx_sync_q(tx_sync_q),
    .tx_sym_q(tx_sym_q), .tone_done_q(tone_done_q), .ones_done_q(ones_done_q),
    .rx_sym(rx_sym), .rx_align(rx_align), .rx_nib(rx_nib), .rx_frame(rx_frame),
    .line_pos(line_pos), .cv_q(cv_q), .rds_col_q(rds_col_q), .rx_out_q(rx_out_q),
    .rx_sync_q(rx_sync_q), .det_zero_q(det_zero_q), .det_ones_q(det_ones_q),
    .det_burst_q(det_burst_q), .det_idle_q(det_idle_q), .wake_q(wake_q));
  tls_far_end far_i (.clk(clk), .rx_sym(rx_sym), .rx_align(rx_align), .rx_nib(rx_nib),
    .rx_frame(rx_frame), .line_pos(line_pos));

  always #20 clk = ~clk;
  always @(negedge clk) if (wake_q === 1'b1) n_wake++;

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  function automatic int pol(input tls_tern_e s);
    return (s == T_POS) ? 1 : (s == T_NEG) ? -1 : 0;
  endfunction : pol
  function automatic tls_tern_e rt();
    int r;
    r = {$random(seed)} % 3;
    return (r == 0) ? T_ZERO : (r == 1) ? T_POS : T_NEG;
  endfunction : rt
  // Far-side view of the transmit stream: taps 18 and 23 from the exchange end, else 5 and 23
  function automatic logic [3:0] dscr(input logic [3:0] r);
    for (int i = 3; i >= 0; i--) begin
      dscr[i] = r[i] ^ dsc_q[is_exch ? 17 : 4] ^ dsc_q[22];
      dsc_q = {dsc_q[21:0], r[i]};
    end
  endfunction : dscr
  task automatic mon_blk(input tls_tern_e a, input tls_tern_e b, input tls_tern_e c);
    logic cv;
    if (sum_m > 4) sum_m = 3;
    else if (sum_m <= 0) sum_m = 1;
    sum_m += pol(a) + pol(b) + pol(c);
    cv = (sum_m < 1) || (sum_m > 4) || (a == T_ZERO && b == T_ZERO && c == T_ZERO);
    if (!cv) col_m = sum_m[2:0];
    far_i.send_sym(a, 1'b1);
    far_i.send_sym(b, 1'b0);
    far_i.send_sym(c, 1'b0);
    chk("cv", cv_q, cv);
    chk("col", rds_col_q, col_m);
  endtask : mon_blk
  task automatic rx_n(input logic [3:0] d);
    far_i.send_nib(d);
    if (n_rx >= 6) chk("rx_out", rx_out_q, {4'h1, d});
    n_rx++;
  endtask : rx_n
  task automatic tx_chk(input logic [3:0] exp);
    @(negedge clk);
    coder_req = 1'b1;
    @(negedge clk);
    coder_req = 1'b0;
    chk("tx_vld", tx_nib_q.vld, 1'b1);
    // Early nibbles precede descrambler sync and are not compared
    if (n_tx >= 6) chk("tx_nib", dscr(tx_nib_q.nib), exp);
    else void'(dscr(tx_nib_q.nib));
    n_tx++;
  endtask : tx_chk

  initial begin
    #(40 * 95000);
    n_mismatch++;
    end_of_test();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk("rst_sym", tx_sym_q, {1'b1, T_ZERO});
    chk("rst_col", rds_col_q, 3'h1);
    mon_blk(T_ZERO, T_ZERO, T_ZERO);
    mon_blk(T_POS, T_POS, T_POS);
    mon_blk(T_POS, T_POS, T_POS);
    mon_blk(T_NEG, T_NEG, T_NEG);
    mon_blk(T_ZERO, T_POS, T_NEG);
    repeat (24) mon_blk(rt(), rt(), rt());
    repeat (30) rx_n($random(seed));
    chk("rx_sync", rx_sync_q, 1'b1);
    for (int v = 0; v < 2; v++) begin
      far_i.frame();
      for (int f = 1; f <= 8; f++) begin
        repeat (3) rx_n(v ? 4'hf : 4'h0);
        far_i.frame();
        chk("det_const", v ? det_ones_q : det_zero_q, f == 8);
        chk("det_burst", det_burst_q, v && f >= 2);
      end
    end
    far_i.frame();
    mon_blk(T_POS, T_NEG, T_ZERO);
    far_i.frame();
    chk("idle_no", det_idle_q, 1'b0);
    mon_blk(T_ZERO, T_ZERO, T_ZERO);
    far_i.frame();
    chk("idle_yes", det_idle_q, 1'b1);
    // Fill the FIFO with the coder stalled, then drain it
    tx_el = EL_DATA;
    tx_in_vld = 1'b1;
    rdy_s = tx_in_rdy;
    repeat (40) begin
      @(negedge clk);
      if (rdy_s) begin
        fq.push_back(tx_in_data);
        tx_in_data = $random(seed);
      end
      rdy_s = tx_in_rdy;
    end
    tx_in_vld = 1'b0;
    chk("fill", fq.size(), FIFO_D);
    while (fq.size() > 0) tx_chk(fq.pop_front());
    chk("sync_data", tx_sync_q, 1'b1);
    @(negedge clk);
    coder_req = 1'b1;
    @(negedge clk);
    coder_req = 1'b0;
    chk("underrun", tx_nib_q.vld, 1'b0);
    foreach (els[k]) begin
      tx_el = els[k];
      repeat (8) tx_chk((els[k] == EL_ONES) ? 4'hf : 4'h0);
      chk("sync_slot", tx_sync_q, els[k] != EL_UNFR0);
    end
    repeat (45) @(negedge clk);
    chk("ones_done", ones_done_q, 1'b1);
    // Exchange end falls back to zeros after the 40-cycle ones timer; subscriber end keeps sending ones
    repeat (8) tx_chk(4'h0);
    is_exch = 1'b0;
    repeat (8) tx_chk(4'hf);
    tx_el = EL_TONE;
    fork
      begin
        w = 0;
        while (tx_sym_q.sym !== T_POS && w < 400) begin
          @(negedge clk);
          w++;
        end
        for (int k = 0; k < TONE_SYMS; k++) begin
          repeat (104) @(negedge clk);
          chk("tone", tx_sym_q, {1'b1, ((k / 8) % 2) ? T_NEG : T_POS});
          // Last step ends one cycle early so the done pulse is seen while it stands
          repeat ((k == TONE_SYMS - 1) ? 103 : 104) @(negedge clk);
        end
        w = 0;
        while (tone_done_q !== 1'b1 && w < 300) begin
          @(negedge clk);
          w++;
        end
        chk("tone_done", tone_done_q, 1'b1);
        tx_el = EL_IDLE;
      end
      begin
        far_i.tone(1000, 16);
        repeat (200) @(negedge clk);
        chk("wake_fast", n_wake, 0);
        far_i.tone(1667, 16);
        repeat (400) @(negedge clk);
        chk("wake", n_wake, 1);
      end
    join
    end_of_test();
  end
endmodule : test_tls_line_sup
`default_nettype wire

// file: tls_far_end.sv
`timescale 1ns/100ps
`default_nettype none
module tls_far_end (
  // Clock
  input wire logic clk,
  // Toward the receive side of the block
  output var tls_pkg::tls_sym_s rx_sym,
  output logic rx_align,
  output var tls_pkg::tls_nib_s rx_nib,
  output logic rx_frame,
  output logic line_pos
);
  import tls_pkg::*;
  logic [22:0] scr_q;
  initial begin
    scr_q = 23'h00_0000;
    rx_sym = {1'b0, T_POS};
    rx_align = 1'b0;
    rx_nib = 5'h05;
    rx_frame = 1'b0;
    line_pos = 1'b0;
  end
  task automatic send_sym(input tls_tern_e s, input logic al);
    @(negedge clk);
    rx_sym <= {1'b1, s};
    rx_align <= al;
    @(negedge clk);
    // Released symbol never repeats the last value
    rx_sym <= {1'b0, (s == T_POS) ? T_NEG : T_POS};
    rx_align <= 1'b0;
  endtask : send_sym
  task automatic send_nib(input logic [3:0] d);
    logic [3:0] n;
    logic b;
    for (int i = 3; i >= 0; i--) begin
      b = d[i] ^ scr_q[4] ^ scr_q[22];
      scr_q = {scr_q[21:0], b};
      n[i] = b;
    end
    @(negedge clk);
    rx_nib <= {1'b1, n};
    @(negedge clk);
    rx_nib <= {1'b0, ~n};
  endtask : send_nib
  task automatic frame();
    @(negedge clk);
    rx_frame <= 1'b1;
    @(negedge clk);
    rx_frame <= 1'b0;
  endtask : frame
  task automatic tone(input int half, input int n);
    repeat (n) begin
      @(negedge clk);
      line_pos <= 1'b1;
      repeat (half) @(negedge clk);
      line_pos <= 1'b0;
      repeat (half - 1) @(negedge clk);
    end
  endtask : tone
endmodule : tls_far_end
`default_nettype wire

// file: tls_line_sup.sv
// Overview of operation
// R1 - Running sum adds +1, 0 or -1 per received ternary symbol.
// R2 - Block end with sum below one or above four flags a code violation.
// R3 - A received all-zero three-symbol block flags a code violation.
// R4 - Error-free block end keeps the sum as next expected column.
// R5 - At block start, sum above 4 reloads 3; sum 0 or less reloads 1.
// R6 - Transmit binary data is scrambled with a 23-stage polynomial before coding.
// R7 - Scrambler forces a stored bit change on constant output.
// R8 - Receive data is self-synchronously descrambled; synchronised after 23 symbols.
// R9 - Wake tones are 16 periods of 8 positive then 8 negative symbols.
// R10 - Unframed zero elements scramble zeros and send zero instead of sync word.
// R11 - Framed zero elements scramble zeros and insert the sync word.
// R12 - Ones element scrambled and framed; downstream it lasts 1 ms.
// R13 - Active elements send scrambled system data framed with the sync word.
// R14 - Idle element sends continuous ternary zero with no frame.
// R15 - Constant zeros or ones reported after 8 consecutive frames.
// R16 - Subscriber end reports ones burst after 16 consecutive ones.
// R17 - Idle reported after one whole frame of zero line level.
// R18 - Activating end sends the tone; far end detects and answers likewise.
// R19 - Wake detector accepts edge periods between 6.15 kHz and 8.89 kHz.
// R20 - After 14 in-range rising edges, wait 0.39 ms quiet before starting.
// R21 - A received all-zero ternary block decodes to binary zero.
// R22 - Taps at stages 5 and 23 or 18 and 23 by direction.
// R23 - Each code violation is a one-cycle flag.
`timescale 1ns/100ps
`default_nettype none
module tls_fifo #(
  parameter int W = 4,
  parameter int D = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_vld,
  input wire logic [W-1:0] in_data,
  output logic in_rdy,
  // Drain side
  output logic out_vld,
  output logic [W-1:0] out_data,
  input wire logic out_rdy
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;
  assign push = in_vld && in_rdy;
  assign pop = out_vld && out_rdy;
  assign out_vld = cnt_q != '0;
  assign out_data = mem[rp_q];
  assign cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
  always_ff @(posedge clk) begin
    if (push) mem[wp_q] <= in_data;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      in_rdy <= 1'b0;
    end else begin
      wp_q <= wp_q + AW'(push);
      rp_q <= rp_q + AW'(pop);
      cnt_q <= cnt_d;
      // Registered ready still lets all D slots fill and keeps the port glitch free
      in_rdy <= cnt_d < (AW + 1)'(D);
    end
  end
endmodule : tls_fifo

module tls_line_sup #(
  parameter int QUIET_CYCLES = tls_pkg::QUIET_CYC,
  parameter int BURST_CYCLES = tls_pkg::BURST_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Mode
  input wire logic is_exch,
  input wire tls_pkg::tls_el_e tx_el,
  // Transmit data from system side
  input wire logic tx_in_vld,
  input wire logic [3:0] tx_in_data,
  output logic tx_in_rdy,
  // Toward block coder and line
  input wire logic coder_req,
  output var tls_pkg::tls_nib_s tx_nib_q,
  output logic tx_sync_q,
  output var tls_pkg::tls_sym_s tx_sym_q,
  output logic tone_done_q,
  output logic ones_done_q,
  // Receive path
  input wire tls_pkg::tls_sym_s rx_sym,
  input wire logic rx_align,
  input wire tls_pkg::tls_nib_s rx_nib,
  input wire logic rx_frame,
  input wire logic line_pos,
  // Supervision results
  output logic cv_q,
  output logic [2:0] rds_col_q,
  output var tls_pkg::tls_nib_s rx_out_q,
  output logic rx_sync_q,
  output logic det_zero_q,
  output logic det_ones_q,
  output logic det_burst_q,
  output logic det_idle_q,
  output logic wake_q
);
  import tls_pkg::*;

  function automatic logic [26:0] scr4(input logic [22:0] r, input logic [3:0] d,
                                       input logic alt, input logic desc);
    logic [22:0] s;
    logic [3:0] o;
    logic b;
    s = r;
    o = '0;
    // First bit sent is the nibble's MSB
    for (int i = 3; i >= 0; i--) begin
      b = d[i] ^ s[alt ? TAP_B - 1 : TAP_A - 1] ^ s[SCR_LEN - 1];
      o[i] = b;
      s = {s[SCR_LEN-2:0], desc ? d[i] : b};
    end
    return {s, o};
  endfunction : scr4

  function automatic logic [2:0] trail1(input logic [3:0] n);
    return n[0] ? (n[1] ? (n[2] ? 3'h3 : 3'h2) : 3'h1) : 3'h0;
  endfunction : trail1

  // Symbol-rate enable
  logic [7:0] div_q;
  logic sym_en;
  assign sym_en = div_q == 8'(SYM_DIV - 1);
  // Restarts with each tone so that its first symbol lasts a full period
  always_ff @(posedge clk) begin
    if (rst || sym_en || tx_el != EL_TONE) div_q <= '0;
    else div_q <= div_q + 8'h01;
  end

  // Transmit source and scrambler
  logic f_vld, f_rdy, force_chg, burst_live;
  logic [3:0] f_data, src;
  logic [22:0] scr_q;
  logic [26:0] sc;
  logic [5:0] run_q;
  logic last_q, framed, src_ok;
  logic [15:0] burst_q;
  tls_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .clk(clk), .rst(rst), .in_vld(tx_in_vld), .in_data(tx_in_data),
    .in_rdy(tx_in_rdy), .out_vld(f_vld), .out_data(f_data), .out_rdy(f_rdy)
  );
  assign f_rdy = coder_req && tx_el == EL_DATA;
  assign burst_live = !is_exch || !ones_done_q;
  // R13 user data source
  assign src = tx_el == EL_DATA ? f_data : (tx_el == EL_ONES && burst_live ? 4'hF : 4'h0);
  assign src_ok = tx_el != EL_DATA || f_vld;
  // R7 forced bit change
  assign force_chg = run_q >= 6'(SUPV_RUN);
  // R6 R22 transmit scramble
  assign sc = scr4(scr_q ^ {22'h00_0000, force_chg}, src, is_exch, 1'b0);
  // R10 R11 R12 sync word only in framed elements
  assign framed = tx_el == EL_FRM0 || tx_el == EL_ONES || tx_el == EL_DATA;
  always_ff @(posedge clk) begin
    if (rst) begin
      scr_q <= '0;
      run_q <= '0;
      last_q <= 1'b0;
      tx_nib_q <= '0;
      tx_sync_q <= 1'b0;
    end else begin
      tx_sync_q <= framed;
      tx_nib_q.vld <= 1'b0;
      if (coder_req && framed | tx_el == EL_UNFR0 && src_ok) begin
        scr_q <= sc[26:4];
        tx_nib_q <= '{vld: 1'b1, nib: sc[3:0]};
        last_q <= sc[0];
        run_q <= sc[3:0] == {4{last_q}} ? (force_chg ? run_q : run_q + 6'h04) : '0;
      end
    end
  end

  // R12 downstream ones element timer
  always_ff @(posedge clk) begin
    if (rst || tx_el != EL_ONES) begin
      burst_q <= '0;
      ones_done_q <= 1'b0;
    end else begin
      ones_done_q <= ones_done_q || burst_q == 16'(BURST_CYCLES - 1);
      if (!ones_done_q) burst_q <= burst_q + 16'h0001;
    end
  end

  // R9 R18 tone and R14 idle symbols
  logic [7:0] tone_cnt_q;
  logic tone_fin_q;
  always_ff @(posedge clk) begin
    if (rst || tx_el != EL_TONE) begin
      tone_cnt_q <= '0;
      tone_fin_q <= 1'b0;
      tone_done_q <= 1'b0;
    end else begin
      tone_done_q <= sym_en && !tone_fin_q && tone_cnt_q == 8'(TONE_SYMS - 1);
      if (sym_en && !tone_fin_q) begin
        tone_cnt_q <= tone_cnt_q + 8'h01;
        tone_fin_q <= tone_cnt_q == 8'(TONE_SYMS - 1);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_sym_q <= '{vld: 1'b1, sym: T_ZERO};
    end else begin
      tx_sym_q.vld <= tx_el == EL_IDLE || tx_el == EL_TONE;
      if (tx_el == EL_TONE && !tone_fin_q) begin
        tx_sym_q.sym <= (tone_cnt_q / 8'(TONE_HALF)) % 8'h02 == 8'h00 ? T_POS : T_NEG;
      end else begin
        tx_sym_q.sym <= T_ZERO;
      end
    end
  end

  // Running sum monitor
  logic [1:0] pos_q, pos;
  logic signed [3:0] rds_q, base, sum_n;
  logic allz_q, allz_n, blk_end, viol;
  assign pos = rx_align ? 2'h0 : pos_q;
  // R5 resynchronising reload
  assign base = pos != 2'h0 ? rds_q : (rds_q > 4'(RDS_MAX) ? 4'(RDS_HI_LOAD) :
                (rds_q <= 4'sh0 ? 4'(RDS_LO_LOAD) : rds_q));
  // R1 symbol polarity sum
  assign sum_n = base + (rx_sym.sym == T_POS ? 4'sh1 : (rx_sym.sym == T_NEG ? -4'sh1 : 4'sh0));
  assign allz_n = (pos == 2'h0 || allz_q) && rx_sym.sym == T_ZERO;
  assign blk_end = rx_sym.vld && pos == 2'(BLK_LAST);
  // R2 R3 violation causes
  assign viol = sum_n < 4'(RDS_MIN) || sum_n > 4'(RDS_MAX) || allz_n;
  always_ff @(posedge clk) begin
    if (rst) begin
      pos_q <= '0;
      rds_q <= 4'(RDS_LO_LOAD);
      allz_q <= 1'b0;
      cv_q <= 1'b0;
      rds_col_q <= 3'(RDS_LO_LOAD);
    end else begin
      // R23 one-cycle flag
      cv_q <= blk_end && viol;
      if (rx_sym.vld) begin
        pos_q <= blk_end ? 2'h0 : pos + 2'h1;
        // R4 sum carried forward
        rds_q <= sum_n;
        allz_q <= allz_n;
        if (blk_end && !viol) rds_col_q <= sum_n[2:0];
      end
    end
  end

  // R8 R21 descrambler; zero nibbles pass as zeros from the decoder
  logic [22:0] dsc_q;
  logic [26:0] dc;
  logic [4:0] dsync_q;
  assign dc = scr4(dsc_q, rx_nib.nib, !is_exch, 1'b1);
  always_ff @(posedge clk) begin
    if (rst) begin
      dsc_q <= '0;
      dsync_q <= '0;
      rx_out_q <= '0;
      rx_sync_q <= 1'b0;
    end else begin
      rx_out_q <= '{vld: rx_nib.vld, nib: dc[3:0]};
      rx_sync_q <= dsync_q >= 5'(DSC_SYNC);
      if (rx_nib.vld) begin
        dsc_q <= dc[26:4];
        if (dsync_q < 5'(DSC_SYNC)) dsync_q <= dsync_q + 5'h04;
      end
    end
  end

  // R15 R16 R17 element detectors
  logic fz_q, fo_q, fl_q, seen_q;
  logic [3:0] zfr_q, ofr_q;
  logic [4:0] run1_q, run1_n;
  assign run1_n = rx_out_q.nib == 4'hF ? (run1_q >= 5'(ONES_RUN) ? run1_q : run1_q + 5'h04) :
                  {2'h0, trail1(rx_out_q.nib)};
  always_ff @(posedge clk) begin
    if (rst) begin
      {fz_q, fo_q, fl_q, seen_q} <= 4'hF;
      {zfr_q, ofr_q} <= '0;
      run1_q <= '0;
      {det_zero_q, det_ones_q, det_burst_q, det_idle_q} <= 4'h0;
    end else begin
      // R16 consecutive ones run
      if (rx_out_q.vld && rx_sync_q) run1_q <= run1_n;
      det_burst_q <= run1_q >= 5'(ONES_RUN);
      if (rx_frame) begin
        // R15 eight constant frames
        zfr_q <= fz_q && !seen_q ? (zfr_q < 4'(FRAMES_DET) ? zfr_q + 4'h1 : zfr_q) : '0;
        ofr_q <= fo_q && !seen_q ? (ofr_q < 4'(FRAMES_DET) ? ofr_q + 4'h1 : ofr_q) : '0;
        det_zero_q <= fz_q && !seen_q && zfr_q >= 4'(FRAMES_DET - 1);
        det_ones_q <= fo_q && !seen_q && ofr_q >= 4'(FRAMES_DET - 1);
        // R17 one zero-level frame
        det_idle_q <= fl_q;
        {fz_q, fo_q, fl_q, seen_q} <= 4'hF;
      end
      if (rx_out_q.vld) begin
        seen_q <= !rx_sync_q;
        fz_q <= fz_q && rx_out_q.nib == 4'h0 && rx_sync_q;
        fo_q <= fo_q && rx_out_q.nib == 4'hF && rx_sync_q;
      end
      if (rx_sym.vld && rx_sym.sym != T_ZERO) fl_q <= 1'b0;
    end
  end

  // Wake tone detector
  tls_wake_e st_q;
  logic pos_d_q, rise, fall, in_rng;
  logic [12:0] per_q;
  logic [3:0] edges_q;
  logic [15:0] qcnt_q;
  assign rise = line_pos && !pos_d_q;
  assign fall = !line_pos && pos_d_q;
  // R19 period window
  assign in_rng = per_q >= 13'(PER_MIN) && per_q <= 13'(PER_MAX);
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= W_HUNT;
      pos_d_q <= 1'b0;
      per_q <= 13'(PER_MAX + 1);
      edges_q <= '0;
      qcnt_q <= '0;
      wake_q <= 1'b0;
    end else begin
      pos_d_q <= line_pos;
      wake_q <= 1'b0;
      if (rise) per_q <= 13'h0001;
      else if (per_q <= 13'(PER_MAX)) per_q <= per_q + 13'h0001;
      case (st_q)
        W_HUNT: begin
          // R20 count in-range rising edges
          if (rise) edges_q <= in_rng ? edges_q + 4'h1 : '0;
          else if (per_q > 13'(PER_MAX)) edges_q <= '0;
          if (rise && in_rng && edges_q == 4'(WAKE_EDGES - 1)) begin
            st_q <= W_QUIET;
            qcnt_q <= '0;
          end
        end
        W_QUIET: begin
          // R18 R20 quiet gap then start activation
          qcnt_q <= fall ? '0 : qcnt_q + 16'h0001;
          if (!fall && qcnt_q == 16'(QUIET_CYCLES - 1)) begin
            wake_q <= 1'b1;
            st_q <= W_HUNT;
            edges_q <= '0;
          end
        end
        default: st_q <= W_HUNT;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_cv_sum_range: assert property (blk_end && (sum_n < 1 || sum_n > 4) |=> cv_q) // R2
    else $error("sum out of range not flagged");
  a_cv_zero_blk: assert property (blk_end && allz_n |=> cv_q) // R3
    else $error("zero block not flagged");
  a_cv_one_cycle: assert property (cv_q |-> $past(blk_end) ##1 !cv_q) // R23
    else $error("violation flag not tied to block end");
  a_rds_hi_reload: assert property (rx_sym.vld && pos == 0 && rds_q > 4 |=> rds_q inside {[2:4]}) // R5
    else $error("high sum not reloaded to 3");
  a_tone_length: assert property ($rose(tone_done_q) |-> $past(tone_cnt_q) == 255) // R9
    else $error("tone not 256 symbols");
  a_dsc_sync_wait: assert property (rx_sync_q |-> dsync_q >= 23) // R8
    else $error("descrambler sync too early");
  a_zero_frames: assert property ($rose(det_zero_q) |-> $past(rx_frame) && $past(zfr_q) == 7) // R15
    else $error("zero element not after 8 frames");
  a_burst_run: assert property ($rose(det_burst_q) |-> $past(run1_q) >= 16) // R16
    else $error("ones burst reported early");
  a_wake_edges: assert property ($rose(st_q == W_QUIET) |-> $past(edges_q) == 13) // R20
    else $error("quiet wait not after 14 edges");
  a_wake_quiet: assert property (wake_q |-> $past(st_q) == W_QUIET && !$past(fall)) // R20
    else $error("wake without quiet gap");
  a_unframed_sync: assert property (tx_el == EL_UNFR0 ##1 tx_el == EL_UNFR0 |-> !tx_sync_q) // R10
    else $error("sync word in unframed element");
  c_code_viol: cover property (cv_q);
  c_wake_found: cover property (wake_q);
  c_tone_done: cover property (tone_done_q);
  c_zeros_found: cover property ($rose(det_zero_q));
endmodule : tls_line_sup
`default_nettype wire

// file: tls_pkg.sv
`default_nettype none
package tls_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD = 120_000;
  localparam int SYM_DIV = CLK_HZ / BAUD;
  localparam int SCR_LEN = 23;
  localparam int TAP_A = 5;
  localparam int TAP_B = 18;
  localparam int SUPV_RUN = 32;
  localparam int RDS_MIN = 1;
  localparam int RDS_MAX = 4;
  localparam int RDS_HI_LOAD = 3;
  localparam int RDS_LO_LOAD = 1;
  localparam int BLK_LAST = 2;
  localparam int DSC_SYNC = 23;
  localparam int TONE_PERIODS = 16;
  localparam int TONE_HALF = 8;
  localparam int TONE_SYMS = TONE_PERIODS * 2 * TONE_HALF;
  localparam int FRAMES_DET = 8;
  localparam int ONES_RUN = 16;
  localparam int WAKE_EDGES = 14;
  localparam int F_LO_HZ = 6150;
  localparam int F_HI_HZ = 8890;
  localparam int PER_MAX = CLK_HZ / F_LO_HZ;
  localparam int PER_MIN = (CLK_HZ + F_HI_HZ - 1) / F_HI_HZ;
  localparam int QUIET_US = 390;
  localparam int QUIET_CYC = CLK_HZ / 1_000_000 * QUIET_US;
  localparam int BURST_US = 1000;
  localparam int BURST_CYC = CLK_HZ / 1_000_000 * BURST_US;
  localparam int FIFO_W = 4;
  localparam int FIFO_D = 32;
  typedef enum logic [1:0] {T_ZERO = 2'h0, T_POS = 2'h1, T_NEG = 2'h3} tls_tern_e;
  typedef enum logic [5:0] {
    EL_IDLE = 6'h01, EL_TONE = 6'h02, EL_UNFR0 = 6'h04,
    EL_FRM0 = 6'h08, EL_ONES = 6'h10, EL_DATA = 6'h20
  } tls_el_e;
  typedef enum logic [1:0] {W_HUNT = 2'h1, W_QUIET = 2'h2} tls_wake_e;
  typedef struct packed {logic vld; tls_tern_e sym;} tls_sym_s;
  typedef struct packed {logic vld; logic [3:0] nib;} tls_nib_s;
endpackage : tls_pkg
`default_nettype wire
